/* cet_params.svh */
// offsets, fields, resets and limits of the can block
`ifndef CET_PARAMS_SVH
`define CET_PARAMS_SVH

`define CET_OFF_CTRL 12'h000
`define CET_OFF_ERRFLAG 12'h004
`define CET_OFF_IER 12'h014
`define CET_OFF_ESR 12'h018
`define CET_OFF_BTR 12'h01c
`define CET_OFF_TXMB_LO 12'h180
`define CET_OFF_TXMB_HI 12'h1ac
`define CET_OFF_RXMB_LO 12'h1b0
`define CET_OFF_RXMB_HI 12'h1cc

`define CET_IER_RESET 32'h0000_0000
`define CET_IER_MASK 32'h0003_8f7f
`define CET_BTR_RESET 32'h0123_0000
`define CET_BTR_MASK 32'hc37f_03ff
`define CET_CTRL_RESET 1'b1

`define CET_IER_TX_EMPTY 0
`define CET_IER_F0_PEND 1
`define CET_IER_F0_FULL 2
`define CET_IER_F0_OVR 3
`define CET_IER_F1_PEND 4
`define CET_IER_F1_FULL 5
`define CET_IER_F1_OVR 6
`define CET_IER_WARN 8
`define CET_IER_PASSIVE 9
`define CET_IER_BUSOFF 10
`define CET_IER_LASTCODE 11
`define CET_IER_ERROR 15
`define CET_IER_WAKEUP 16
`define CET_IER_SLEEP 17

`define CET_ESR_REC_LSB 24
`define CET_ESR_TEC_LSB 16
`define CET_ESR_LEC_LSB 4
`define CET_ESR_BUSOFF 2
`define CET_ESR_PASSIVE 1
`define CET_ESR_WARN 0

`define CET_BTR_SILENT 31
`define CET_BTR_LOOPBACK 30
`define CET_BTR_SJW_LSB 24
`define CET_BTR_TS2_LSB 20
`define CET_BTR_TS1_LSB 16
`define CET_BTR_BRP_LSB 0

`define CET_LEC_NONE 3'h0
`define CET_LEC_SOFT 3'h7
`define CET_REC_RELOAD 8'h78
`define CET_REC_HIGH 8'h80
`define CET_PASSIVE_LIMIT 9'h07f
`define CET_WARN_LIMIT 9'h060
`define CET_TEC_BUSOFF 9'h0ff
`define CET_STEP_BIG 4'h8

`define CET_RESP_OKAY 2'h0
`define CET_RESP_SLVERR 2'h2
`endif

/* cet_pkg.sv */
// types shared by the can error/timing block
package cet_pkg;
    // bit-time phases, gray coded along sync -> seg1 -> seg2
    typedef enum logic [1:0] {
        CET_SYNC = 2'b00,
        CET_SEG1 = 2'b01,
        CET_SEG2 = 2'b11
    } cet_phase_t;
endpackage : cet_pkg

/* cet_mbox_mem.sv */
// mailbox storage with byte writes and two registered read ports
`timescale 1ns/1ps
`default_nettype none
module cet_mbox_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 12,
    parameter int AW = 4
) (
    // clock
    input wire logic clock,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [WIDTH/8-1:0] wr_strb,
    // bus read port
    input wire logic [AW-1:0] rd_a_addr,
    output logic [WIDTH-1:0] rd_a_data,
    // frame logic read port
    input wire logic [AW-1:0] rd_b_addr,
    output logic [WIDTH-1:0] rd_b_data
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en && (int'(wr_addr) < DEPTH)) begin
            for (int i = 0; i < WIDTH / 8; i++) begin
                if (wr_strb[i]) begin
                    mem_q[wr_addr][i*8 +: 8] <= wr_data[i*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        rd_a_data <= (int'(rd_a_addr) < DEPTH) ? mem_q[rd_a_addr] : '0;
        rd_b_data <= (int'(rd_b_addr) < DEPTH) ? mem_q[rd_b_addr] : '0;
    end
endmodule : cet_mbox_mem
`default_nettype wire

/* cet_top.sv */
// can error, interrupt, bit timing and mailbox registers over axi4-lite
// Function
// - bits 17/16 gate sleep and wakeup flags onto irq_status
// - bit 15 gates pending error flag onto irq_status
// - bit 11: hardware error code update sets error flag
// - bits 10/9/8: bus-off, passive, warning rises set error flag
// - bits 6/5/4 gate fifo 1 overrun, full, pending
// - bits 3/2/1 gate fifo 0 overrun, full, pending
// - bit 0 gates request-completed flags onto irq_tx
// - receive errors add 1 or 8 to 8-bit receive counter
// - good reception: minus 1, or reload 120 above 128
// - 9-bit transmit counter, low byte read-only at 23:16
// - 3-bit last error code at 6:4; hardware never writes 7
// - error-free transfer clears code; software may preload 7
// - transmit counter above 255 sets bus-off
// - either counter above 127 sets passive
// - either counter at least 96 sets warning
// - bit timing writable only in init mode
// - bit 31 silent mode, bit 30 loopback
// - resync moves a bit edge at most jump width plus one quanta
// - segments two and one last field plus one quanta
// - one quantum is prescaler plus one clock periods
// - three transmit, two receive mailboxes; receive shows oldest
// - receive mailboxes read-only; transmit mailbox writable only when empty
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "cet_params.svh"
module cet_top
    import cet_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int TX_MBOX = 3,
    parameter int RX_MBOX = 2
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // error events from frame logic
    input wire logic rx_err_inc1,
    input wire logic rx_err_inc8,
    input wire logic rx_ok,
    input wire logic tx_err_inc8,
    input wire logic tx_ok,
    input wire logic err_detect,
    input wire logic [2:0] err_code,
    input wire logic busoff_recover,
    // status levels from frame logic
    input wire logic sleep_ack_flag,
    input wire logic wakeup_flag,
    input wire logic [1:0] fifo0_pending_count,
    input wire logic fifo0_full_flag,
    input wire logic fifo0_overrun_flag,
    input wire logic [1:0] fifo1_pending_count,
    input wire logic fifo1_full_flag,
    input wire logic fifo1_overrun_flag,
    input wire logic [TX_MBOX-1:0] request_completed_flag,
    input wire logic [TX_MBOX-1:0] tx_mailbox_empty_flag,
    // mailbox data path
    input wire logic [RX_MBOX*128-1:0] rx_mbox_words,
    input wire logic [3:0] tx_rd_addr,
    output logic [31:0] tx_rd_data,
    // bit timing
    input wire logic rx_edge,
    output logic quantum_tick,
    output logic bit_start,
    output logic sample_point,
    // modes and states
    output logic init_mode,
    output logic silent_select,
    output logic loopback_select,
    output logic busoff_state,
    output logic passive_state,
    // interrupt lines
    output logic irq_tx,
    output logic irq_fifo0,
    output logic irq_fifo1,
    output logic irq_status
);
    logic [31:0] ier_q;
    logic [31:0] btr_q;
    logic init_q;
    logic err_flag_q;
    logic [7:0] rec_q;
    logic [8:0] tec_q;
    logic [2:0] lec_q;
    logic busoff_q;
    logic passive_prev_q;
    logic warn_prev_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rd_pend_q;
    logic [11:0] rd_addr_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [31:0] mem_rdata;

    logic wr_go;
    logic [11:0] wa;
    logic [11:0] ra;
    logic [31:0] wmask;
    logic passive_now;
    logic warn_now;
    logic wr_tx_ok;
    logic [3:0] wr_tx_idx;
    logic [3:0] rd_tx_idx;

    assign wa = 12'(s_axi_awaddr);
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
        end
    end

    // mailbox in addr[5:4], word in addr[3:2]
    assign wr_tx_idx = 4'({wa[5:4] - 2'(`CET_OFF_TXMB_LO >> 4), wa[3:2]});
    assign wr_tx_ok = (wa >= `CET_OFF_TXMB_LO) && (wa <= `CET_OFF_TXMB_HI)
        && tx_mailbox_empty_flag[wr_tx_idx[3:2]];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= `CET_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            case (wa)
                `CET_OFF_CTRL, `CET_OFF_ERRFLAG, `CET_OFF_IER, `CET_OFF_ESR, `CET_OFF_BTR: bresp_q <= `CET_RESP_OKAY;
                // mailbox writes answer okay even when dropped
                default: bresp_q <= (wa >= `CET_OFF_TXMB_LO && wa <= `CET_OFF_RXMB_HI) ?
                    `CET_RESP_OKAY : `CET_RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            init_q <= `CET_CTRL_RESET;
        end else if (wr_go && wa == `CET_OFF_CTRL && s_axi_wstrb[0]) begin
            init_q <= s_axi_wdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ier_q <= `CET_IER_RESET;
        end else if (wr_go && wa == `CET_OFF_IER) begin
            ier_q <= ((ier_q & ~wmask) | (s_axi_wdata & wmask)) & `CET_IER_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            btr_q <= `CET_BTR_RESET;
        end else if (wr_go && wa == `CET_OFF_BTR && init_q) begin
            btr_q <= ((btr_q & ~wmask) | (s_axi_wdata & wmask)) & `CET_BTR_MASK;
        end
    end

    assign init_mode = init_q;
    assign silent_select = btr_q[`CET_BTR_SILENT];
    assign loopback_select = btr_q[`CET_BTR_LOOPBACK];

    always_ff @(posedge clock) begin
        if (!rst_n || busoff_recover) begin
            rec_q <= '0;
        end else if (rx_err_inc8) begin
            rec_q <= (rec_q > 8'hff - 8'(`CET_STEP_BIG)) ? 8'hff : rec_q + 8'(`CET_STEP_BIG);
        end else if (rx_err_inc1) begin
            rec_q <= (rec_q == 8'hff) ? rec_q : rec_q + 8'h01;
        end else if (rx_ok) begin
            if (rec_q > `CET_REC_HIGH) begin
                rec_q <= `CET_REC_RELOAD;
            end else if (rec_q != 8'h00) begin
                rec_q <= rec_q - 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || busoff_recover) begin
            tec_q <= '0;
        end else if (tx_err_inc8) begin
            tec_q <= (tec_q > 9'h1ff - 9'(`CET_STEP_BIG)) ? 9'h1ff : tec_q + 9'(`CET_STEP_BIG);
        end else if (tx_ok && tec_q != 9'h000) begin
            tec_q <= tec_q - 9'h001;
        end
    end

    assign passive_now = ({1'b0, rec_q} > `CET_PASSIVE_LIMIT) || (tec_q > `CET_PASSIVE_LIMIT);
    assign warn_now = ({1'b0, rec_q} >= `CET_WARN_LIMIT) || (tec_q >= `CET_WARN_LIMIT);

    always_ff @(posedge clock) begin
        if (!rst_n || busoff_recover) begin
            busoff_q <= 1'b0;
        end else if (tec_q > `CET_TEC_BUSOFF) begin
            busoff_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            passive_prev_q <= 1'b0;
            warn_prev_q <= 1'b0;
        end else begin
            passive_prev_q <= passive_now;
            warn_prev_q <= warn_now;
        end
    end

    assign busoff_state = busoff_q;
    assign passive_state = passive_now;

    // hardware code update beats a software write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            lec_q <= `CET_LEC_NONE;
        end else if (err_detect && err_code != `CET_LEC_SOFT) begin
            lec_q <= err_code;
        end else if (rx_ok || tx_ok) begin
            lec_q <= `CET_LEC_NONE;
        end else if (wr_go && wa == `CET_OFF_ESR && s_axi_wstrb[0]) begin
            lec_q <= s_axi_wdata[`CET_ESR_LEC_LSB +: 3];
        end
    end

    // sticky error flag, write 1 clears, set wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            err_flag_q <= 1'b0;
        end else if ((ier_q[`CET_IER_LASTCODE] && err_detect && err_code != `CET_LEC_SOFT)
            || (ier_q[`CET_IER_BUSOFF] && tec_q > `CET_TEC_BUSOFF && !busoff_q)
            || (ier_q[`CET_IER_PASSIVE] && passive_now && !passive_prev_q)
            || (ier_q[`CET_IER_WARN] && warn_now && !warn_prev_q)) begin
            err_flag_q <= 1'b1;
        end else if (wr_go && wa == `CET_OFF_ERRFLAG && s_axi_wstrb[0] && s_axi_wdata[0]) begin
            err_flag_q <= 1'b0;
        end
    end

    assign irq_tx = ier_q[`CET_IER_TX_EMPTY] && (|request_completed_flag);
    assign irq_fifo0 = (ier_q[`CET_IER_F0_PEND] && fifo0_pending_count != 2'b00)
        || (ier_q[`CET_IER_F0_FULL] && fifo0_full_flag)
        || (ier_q[`CET_IER_F0_OVR] && fifo0_overrun_flag);
    assign irq_fifo1 = (ier_q[`CET_IER_F1_PEND] && fifo1_pending_count != 2'b00)
        || (ier_q[`CET_IER_F1_FULL] && fifo1_full_flag)
        || (ier_q[`CET_IER_F1_OVR] && fifo1_overrun_flag);
    assign irq_status = (ier_q[`CET_IER_ERROR] && err_flag_q)
        || (ier_q[`CET_IER_SLEEP] && sleep_ack_flag)
        || (ier_q[`CET_IER_WAKEUP] && wakeup_flag);

    assign ra = 12'(s_axi_araddr);
    assign rd_tx_idx = 4'({ra[5:4] - 2'(`CET_OFF_TXMB_LO >> 4), ra[3:2]});

    cet_mbox_mem #(
        .WIDTH(32),
        .DEPTH(TX_MBOX * 4),
        .AW(4)
    ) u_txmb (
        .clock(clock),
        .wr_en(wr_go && wr_tx_ok),
        .wr_addr(wr_tx_idx),
        .wr_data(s_axi_wdata),
        .wr_strb(s_axi_wstrb),
        .rd_a_addr(rd_tx_idx),
        .rd_a_data(mem_rdata),
        .rd_b_addr(tx_rd_addr),
        .rd_b_data(tx_rd_data)
    );

    assign s_axi_arready = !rd_pend_q && !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rd_pend_q <= 1'b1;
            rd_addr_q <= ra;
        end else begin
            rd_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `CET_RESP_OKAY;
        end else if (rd_pend_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= `CET_RESP_OKAY;
            case (rd_addr_q)
                `CET_OFF_CTRL: rdata_q <= {31'h0, init_q};
                `CET_OFF_ERRFLAG: rdata_q <= {31'h0, err_flag_q};
                `CET_OFF_IER: rdata_q <= ier_q;
                `CET_OFF_ESR: begin
                    rdata_q <= '0;
                    rdata_q[`CET_ESR_REC_LSB +: 8] <= rec_q;
                    rdata_q[`CET_ESR_TEC_LSB +: 8] <= tec_q[7:0];
                    rdata_q[`CET_ESR_LEC_LSB +: 3] <= lec_q;
                    rdata_q[`CET_ESR_BUSOFF] <= busoff_q;
                    rdata_q[`CET_ESR_PASSIVE] <= passive_now;
                    rdata_q[`CET_ESR_WARN] <= warn_now;
                end
                `CET_OFF_BTR: rdata_q <= btr_q;
                default: begin
                    if (rd_addr_q >= `CET_OFF_TXMB_LO && rd_addr_q <= `CET_OFF_TXMB_HI) begin
                        rdata_q <= mem_rdata;
                    end else if (rd_addr_q >= `CET_OFF_RXMB_LO && rd_addr_q <= `CET_OFF_RXMB_HI) begin
                        // oldest message of each receive fifo
                        rdata_q <= rx_mbox_words[32 * int'((rd_addr_q - `CET_OFF_RXMB_LO) >> 2) +: 32];
                    end else begin
                        rdata_q <= '0;
                        rresp_q <= `CET_RESP_SLVERR;
                    end
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    cet_phase_t phase_q;
    logic [9:0] presc_q;
    logic [4:0] qcnt_q;
    logic [2:0] ext_q;
    logic [2:0] jump;
    logic [4:0] seg1_end;
    logic [4:0] seg2_left;

    assign jump = 3'(btr_q[`CET_BTR_SJW_LSB +: 2]) + 3'h1;
    assign seg1_end = 5'(btr_q[`CET_BTR_TS1_LSB +: 4]) + 5'(ext_q);
    assign seg2_left = 5'(btr_q[`CET_BTR_TS2_LSB +: 3]) - qcnt_q;
    assign quantum_tick = !init_q && presc_q == btr_q[`CET_BTR_BRP_LSB +: 10];

    always_ff @(posedge clock) begin
        if (!rst_n || init_q || quantum_tick) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 10'h001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || init_q) begin
            phase_q <= CET_SYNC;
            qcnt_q <= '0;
            ext_q <= '0;
            bit_start <= 1'b0;
            sample_point <= 1'b0;
        end else begin
            bit_start <= 1'b0;
            sample_point <= 1'b0;
            if (rx_edge && phase_q == CET_SEG2) begin
                // early edge: cut segment two, at most the jump width
                if (seg2_left <= 5'(jump)) begin
                    phase_q <= CET_SYNC;
                    qcnt_q <= '0;
                end else begin
                    qcnt_q <= qcnt_q + 5'(jump);
                end
            end else begin
                if (rx_edge && phase_q == CET_SEG1) begin
                    // late edge: stretch segment one, at most the jump width
                    ext_q <= ((qcnt_q + 5'h01) < 5'(jump)) ? 3'(qcnt_q + 5'h01) : jump;
                end
                if (quantum_tick) begin
                    case (phase_q)
                        CET_SYNC: begin
                            phase_q <= CET_SEG1;
                            qcnt_q <= '0;
                            ext_q <= '0;
                            bit_start <= 1'b1;
                        end
                        CET_SEG1: begin
                            if (qcnt_q >= seg1_end) begin
                                phase_q <= CET_SEG2;
                                qcnt_q <= '0;
                                sample_point <= 1'b1;
                            end else begin
                                qcnt_q <= qcnt_q + 5'h01;
                            end
                        end
                        CET_SEG2: begin
                            if (seg2_left == 5'h00) begin
                                phase_q <= CET_SYNC;
                                qcnt_q <= '0;
                            end else begin
                                qcnt_q <= qcnt_q + 5'h01;
                            end
                        end
                        default: begin
                            phase_q <= CET_SYNC;
                            qcnt_q <= '0;
                        end
                    endcase
                end
            end
        end
    end
endmodule : cet_top
`default_nettype wire

/* cet_top_monitor.sv */
// port assertions for the can error and timing block
`timescale 1ns/1ps
`default_nettype none
module cet_top_monitor #(
    parameter int TX_MBOX = 3
) (
    // clock and reset
    input wire logic clock, rst_n,
    // bus handshakes
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_bvalid, s_axi_bready,
    input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire logic [1:0] s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // status levels and events
    input wire logic [1:0] fifo0_pending_count, fifo1_pending_count,
    input wire logic fifo0_full_flag, fifo0_overrun_flag, fifo1_full_flag, fifo1_overrun_flag,
    input wire logic busoff_recover,
    input wire logic [TX_MBOX-1:0] request_completed_flag,
    // watched outputs
    input wire logic irq_tx, irq_fifo0, irq_fifo1, irq_status, busoff_state,
    input wire logic init_mode, quantum_tick, silent_select, loopback_select
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write unanswered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_rvalid ##1 s_axi_rvalid)
        else $error("read latency wrong");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    a_fifo1_gate: assert property (irq_fifo1 |-> fifo1_pending_count != 2'h0 || fifo1_full_flag || fifo1_overrun_flag)
        else $error("fifo1 irq without cause");
    a_fifo0_gate: assert property (irq_fifo0 |-> fifo0_pending_count != 2'h0 || fifo0_full_flag || fifo0_overrun_flag)
        else $error("fifo0 irq without cause");
    a_tx_gate: assert property (irq_tx |-> |request_completed_flag)
        else $error("tx irq without cause");
    a_busoff_sticky: assert property (busoff_state && !busoff_recover |=> busoff_state)
        else $error("bus-off left early");
    a_init_quiet: assert property (init_mode |-> !quantum_tick)
        else $error("quantum in init");
    a_mode_frozen: assert property (!init_mode |=> $stable(silent_select) && $stable(loopback_select))
        else $error("timing changed outside init");
    cover property (busoff_state);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property (irq_status && irq_fifo1);
endmodule : cet_top_monitor
bind cet_top cet_top_monitor #(.TX_MBOX(TX_MBOX)) cet_top_monitor_i (.*);
`default_nettype wire

/* cet_frame_model.sv */
// frame logic stand-in that pulses error and success events
`timescale 1ns/1ps
`default_nettype none
module cet_frame_model (
    // clock
    input wire logic clock,
    // event pulses and error code
    output logic rx_err_inc1, rx_err_inc8, rx_ok, tx_err_inc8, tx_ok, err_detect, busoff_recover,
    output logic [2:0] err_code
);
    logic [6:0] ev = '0;
    assign {busoff_recover, err_detect, tx_ok, tx_err_inc8, rx_ok, rx_err_inc8, rx_err_inc1} = ev;
    initial err_code = 3'h5;
    // n one-cycle pulses of kind k
    task automatic send(input int k, input int n, input logic [2:0] c);
        repeat (n) begin
            @(posedge clock);
            ev[k] <= 1'h1;
            err_code <= c;
            @(posedge clock);
            ev[k] <= 1'h0;
            err_code <= ~c;
        end
    endtask : send
endmodule : cet_frame_model
`default_nettype wire

/* test_cet_top.sv */
// directed bench for the can error and timing block
`timescale 1ns/1ps
`default_nettype none
`include "cet_params.svh"
module test_cet_top;
    logic clock = '0;
    logic rst_n = '0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, tx_rd_data, rdat;
    logic [3:0] s_axi_wstrb = 4'hf, tx_rd_addr = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, rx_edge = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, fifo0_pending_count = 2'h1, fifo1_pending_count = 2'h2;
    logic rx_err_inc1, rx_err_inc8, rx_ok, tx_err_inc8, tx_ok, err_detect, busoff_recover;
    logic [2:0] err_code, request_completed_flag = 3'h4, tx_mailbox_empty_flag = 3'h7;
    logic sleep_ack_flag = '1, wakeup_flag = '1, fifo0_full_flag = '1, fifo0_overrun_flag = '1;
    logic fifo1_full_flag = '1, fifo1_overrun_flag = '1;
    logic [255:0] rx_mbox_words = {8{32'h1234_5678}};
    logic quantum_tick, bit_start, sample_point, init_mode, silent_select, loopback_select;
    logic busoff_state, passive_state, irq_tx, irq_fifo0, irq_fifo1, irq_status;
    int fails = 0, num_checks = 0, n;
    int ebit[9] = '{0, 1, 2, 3, 4, 5, 6, 16, 17};
    logic [3:0] eirq[9] = '{4'h1, 4'h2, 4'h2, 4'h2, 4'h4, 4'h4, 4'h4, 4'h8, 4'h8};
    cet_top cet_top_i (.*);
    cet_frame_model cet_frame_model_i (.*);
    always #25 clock = ~clock;
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge clock); while (!(s_axi_awready && s_axi_wready));
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge clock); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= '0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= '0;
        do @(posedge clock); while (!s_axi_rvalid);
        {rdat, resp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= '0;
    endtask : rd
    task automatic rchk(input logic [11:0] a, input string s, input logic [31:0] e);
        rd(a);
        chk(s, rdat, e);
    endtask : rchk
    // k: 0 rx+1, 1 rx+8, 2 rx ok, 3 tx+8, 5 error code
    task automatic fire(input int k, input int cnt, input logic [2:0] c = 3'h0);
        cet_frame_model_i.send(k, cnt, c);
        repeat (3) @(posedge clock);
    endtask : fire
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    initial begin
        #1000000;
        fails++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'h1;
        rchk(`CET_OFF_ESR, "esr", 32'h0);
        rchk(`CET_OFF_BTR, "btr", 32'h0123_0000);
        rd(12'h100);
        chk("unmapped", resp, 32'h2);
        $display("test reset done");
        wr(`CET_OFF_IER, 32'h0);
        chk("irq off", {irq_status, irq_fifo1, irq_fifo0, irq_tx}, 32'h0);
        foreach (ebit[k]) begin
            wr(`CET_OFF_IER, 32'h1 << ebit[k]);
            chk("irq", {irq_status, irq_fifo1, irq_fifo0, irq_tx}, eirq[k]);
        end
        wr(`CET_OFF_IER, 32'hffff_ffff);
        rchk(`CET_OFF_IER, "ier", 32'h0003_8f7f);
        {fifo0_full_flag, fifo0_overrun_flag, fifo0_pending_count} <= '0;
        wr(`CET_OFF_IER, 32'h0000_007e);
        chk("fifo levels", {irq_fifo1, irq_fifo0}, 32'h2);
        $display("test irq done");
        wr(`CET_OFF_IER, 32'h0);
        fire(1, 11);
        rchk(`CET_OFF_ESR, "rec 88", 32'h5800_0000);
        fire(1, 1);
        rchk(`CET_OFF_ESR, "rec 96", 32'h6000_0001);
        fire(1, 4);
        rchk(`CET_OFF_ESR, "rec 128", 32'h8000_0003);
        fire(2, 1);
        rchk(`CET_OFF_ESR, "rec 127", 32'h7f00_0001);
        fire(0, 2);
        fire(2, 1);
        rchk(`CET_OFF_ESR, "reload", 32'h7800_0001);
        wr(`CET_OFF_IER, 32'h0000_8800);
        fire(5, 1, 3'h3);
        rchk(`CET_OFF_ESR, "lec", 32'h7800_0031);
        chk("err irq", irq_status, 32'h1);
        fire(2, 1);
        rchk(`CET_OFF_ESR, "lec clear", 32'h7700_0001);
        wr(`CET_OFF_ESR, 32'h70);
        fire(5, 1, 3'h1);
        fire(5, 1, 3'h7);
        rchk(`CET_OFF_ESR, "lec hw", 32'h7700_0011);
        wr(`CET_OFF_IER, 32'h0000_8400);
        wr(`CET_OFF_ERRFLAG, 32'h1);
        fire(3, 31);
        chk("no busoff", {busoff_state, irq_status}, 32'h0);
        fire(3, 1);
        rchk(`CET_OFF_ESR, "busoff", 32'h7700_0017);
        chk("busoff irq", {busoff_state, irq_status}, 32'h3);
        $display("test counters done");
        wr(`CET_OFF_BTR, 32'hffff_ffff);
        rchk(`CET_OFF_BTR, "btr", 32'hc37f_03ff);
        chk("modes", {silent_select, loopback_select}, 32'h3);
        wr(`CET_OFF_BTR, 32'h0000_0004);
        wr(`CET_OFF_CTRL, 32'h0);
        wr(`CET_OFF_BTR, 32'h4000_0000);
        rchk(`CET_OFF_BTR, "btr locked", 32'h0000_0004);
        do @(posedge clock); while (!quantum_tick);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (!quantum_tick);
        chk("quantum", n, 32'h5);
        wr(12'h180, 32'h0000_00a5);
        tx_mailbox_empty_flag <= '0;
        wr(12'h180, 32'h0000_005a);
        chk("tx mbox", tx_rd_data, 32'h0000_00a5);
        wr(12'h1b0, 32'h0);
        rchk(12'h1b0, "rx mbox", 32'h1234_5678);
        $display("test timing and mailbox done");
        close_out();
    end
endmodule : test_cet_top
`default_nettype wire
